// ### hw/mtc_pkg.sv
// How it works
// - Standby pin low forces hardware standby; high means normal converting.
// - Overtemp pin pulls low while channel 1 or 4 exceeds its limit.
// - Alert pin pulls low while any channel exceeds its alert threshold.
// - Default order: remote 1, remote 2, remote 3, local, remote 4, repeat.
// - Each finished conversion is stored in that channel's temperature register.
// - Config bit 4 interleaves remote 1: 1,2,1,3,1,local,1,4.
// - Halt bit in config 1 gives software standby, converter disabled.
// - Hardware standby stops the converter clock; no conversions happen.
// - Standby keeps all temperature and threshold data; bus stays responsive.
// - Bus timeout is armed only after a START is seen.
// - Standby during conversion aborts it; temperature registers keep old values.
// - Bus clock low longer than timeout (25 ms at 100 MHz clock) resets interface.
// - Receive byte returns register chosen by last command byte.
`default_nettype none
package mtc_pkg;
	// ====================================================
	// Timing
	localparam int CLK_MHZ        = 100;
	localparam int TIMEOUT_MIN_MS = 25;
	localparam int TIMEOUT_CYC    = TIMEOUT_MIN_MS * 1000 * CLK_MHZ;
	// ====================================================
	// Register map
	localparam logic [7:0] A_TEMP     = 8'h00;
	localparam logic [7:0] A_ALERT    = 8'h10;
	localparam logic [7:0] A_OVT1     = 8'h20;
	localparam logic [7:0] A_OVT4     = 8'h21;
	localparam logic [7:0] A_CFG1     = 8'h30;
	localparam logic [7:0] A_ALARM    = 8'h31;
	localparam logic [7:0] A_IRQ_STAT = 8'h40;
	localparam logic [7:0] A_IRQ_EN   = 8'h41;
	localparam logic [7:0] A_IRQ_CLR  = 8'h42;
	localparam logic [7:0] A_PINS     = 8'h43;
	// ====================================================
	// Fields and reset values
	localparam int         CFG_ILV_BIT  = 4;
	localparam int         CFG_HALT_BIT = 6;
	localparam int         IRQ_SEQ      = 0;
	localparam int         IRQ_ALERT    = 1;
	localparam int         IRQ_OVT      = 2;
	localparam int         IRQ_TMO      = 3;
	localparam int         IRQ_ABORT    = 4;
	localparam logic [7:0] RST_TEMP     = 8'h00;
	localparam logic [7:0] RST_ALERT    = 8'h50;
	localparam logic [7:0] RST_OVT      = 8'h64;
	localparam logic [7:0] RST_CFG      = 8'h00;
	localparam logic [7:0] RST_IRQ_EN   = 8'h00;
	// ====================================================
	// Channels and sequence
	localparam int         NUM_CH       = 5;
	localparam logic [2:0] CH_LOCAL     = 3'h0;
	localparam logic [2:0] CH_R1        = 3'h1;
	localparam logic [2:0] CH_R2        = 3'h2;
	localparam logic [2:0] CH_R3        = 3'h3;
	localparam logic [2:0] CH_R4        = 3'h4;
	localparam logic [2:0] SEQ_LAST_DEF = 3'h4;
	localparam logic [2:0] SEQ_LAST_ILV = 3'h7;
	// ====================================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} mtc_wr_t;
	typedef struct packed {
		logic       start;
		logic       abort;
		logic [2:0] channel;
	} mtc_conv_t;
	typedef struct packed {
		logic       done;
		logic [7:0] result;
	} mtc_res_t;
endpackage : mtc_pkg
`default_nettype wire

// ### hw/mtc_smb.sv
`timescale 1ns/1ps
`default_nettype none
module mtc_smb #(
	parameter int         TIMEOUT_CYC = mtc_pkg::TIMEOUT_CYC,
	parameter logic [6:0] SLAVE_ADDR  = 7'h2a
) (
	input  wire logic            i_clock,
	input  wire logic            i_rst,
	input  wire logic            i_scl,
	input  wire logic            i_sda,
	input  wire logic [7:0]      i_rdata,
	output logic                 o_sda_oe,
	output logic [7:0]           o_cmd,
	output mtc_pkg::mtc_wr_t     o_wr,
	output logic                 o_timeout
);
	import mtc_pkg::*;
	typedef enum {SB_IDLE, SB_ADDR, SB_CMD, SB_WDATA, SB_RDATA, SB_SKIP} mtc_sb_t;
	// ====================================================
	// Line filters and timeout
	logic [1:0]  s1, s2, s3, filt, prev, next_filt;
	logic [31:0] cnt, next_cnt;
	logic        armed, next_armed, next_timeout;
	logic        scl, sda, scl_rise, scl_fall, start, stop, tmo_hit;
	mtc_sb_t     state, next_state;
	logic [3:0]  bits, next_bits;
	logic [7:0]  sh, next_sh, tx, next_tx, next_cmd;
	logic        ack, next_ack, next_oe;
	mtc_wr_t     next_wr;
	always_comb begin
		next_filt = (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
		scl = filt[1];
		sda = filt[0];
		scl_rise = scl & ~prev[1];
		scl_fall = ~scl & prev[1];
		start = scl & prev[1] & prev[0] & ~sda;
		stop = scl & prev[1] & ~prev[0] & sda;
		tmo_hit = armed && !scl && cnt >= 32'(TIMEOUT_CYC - 1);
		next_cnt = (armed && !scl) ? cnt + 32'h1 : 32'h0;
		next_armed = armed;
		next_timeout = 1'b0;
		if (start) begin
			next_armed = 1'b1;
		end else if (stop) begin
			next_armed = 1'b0;
		end else if (tmo_hit) begin
			next_armed = 1'b0;
			next_timeout = 1'b1;
			next_cnt = 32'h0;
		end
	end
	// ====================================================
	// Byte engine
	// Command byte persists between transactions so receive byte reuses it
	always_comb begin
		next_state = state;
		next_bits = bits;
		next_ack = ack;
		next_sh = sh;
		next_tx = tx;
		next_oe = o_sda_oe;
		next_cmd = o_cmd;
		next_wr = '0;
		if (start) begin
			next_state = SB_ADDR;
			next_bits = 4'h0;
			next_ack = 1'b0;
			next_oe = 1'b0;
		end else if (stop || tmo_hit) begin
			next_state = SB_IDLE;
			next_ack = 1'b0;
			next_oe = 1'b0;
		end else if (scl_rise && !ack && bits < 4'h8) begin
			next_sh = {sh[6:0], sda};
			next_bits = bits + 4'h1;
		end else if (scl_fall) begin
			if (ack) begin
				next_ack = 1'b0;
				next_bits = 4'h0;
				next_oe = 1'b0;
				case (state)
					SB_ADDR: begin
						if (sh[0]) begin
							next_state = SB_RDATA;
							next_tx = i_rdata;
							next_oe = ~i_rdata[7];
						end else begin
							next_state = SB_CMD;
						end
					end
					SB_CMD: next_state = SB_WDATA;
					default: next_state = SB_SKIP;
				endcase
			end else if (bits == 4'h8) begin
				case (state)
					SB_ADDR: begin
						if (sh[7:1] == SLAVE_ADDR) begin
							next_ack = 1'b1;
							next_oe = 1'b1;
						end else begin
							next_state = SB_SKIP;
						end
					end
					SB_CMD: begin
						next_ack = 1'b1;
						next_oe = 1'b1;
						next_cmd = sh;
					end
					SB_WDATA: begin
						next_ack = 1'b1;
						next_oe = 1'b1;
						next_wr = '{wr: 1'b1, addr: o_cmd, data: sh};
					end
					SB_RDATA: begin
						next_ack = 1'b1;
						next_oe = 1'b0;
					end
					default: next_state = SB_SKIP;
				endcase
			end else if (state == SB_RDATA) begin
				next_oe = ~tx[3'(4'h7 - bits)];
			end
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s1 <= 2'h3;
			s2 <= 2'h3;
			s3 <= 2'h3;
			filt <= 2'h3;
			prev <= 2'h3;
			cnt <= 32'h0;
			armed <= 1'b0;
			o_timeout <= 1'b0;
			state <= SB_IDLE;
			bits <= 4'h0;
			ack <= 1'b0;
			sh <= 8'h00;
			tx <= 8'h00;
			o_sda_oe <= 1'b0;
			o_cmd <= 8'h00;
			o_wr <= '0;
		end else begin
			s1 <= {i_scl, i_sda};
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
			prev <= filt;
			cnt <= next_cnt;
			armed <= next_armed;
			o_timeout <= next_timeout;
			state <= next_state;
			bits <= next_bits;
			ack <= next_ack;
			sh <= next_sh;
			tx <= next_tx;
			o_sda_oe <= next_oe;
			o_cmd <= next_cmd;
			o_wr <= next_wr;
		end
	end
	a_tmo_armed: assert property (@(posedge i_clock) disable iff (i_rst)
		o_timeout |-> $past(armed) && !armed) else $error("timeout fired unarmed");
	a_tmo_release: assert property (@(posedge i_clock) disable iff (i_rst)
		o_timeout |=> !o_sda_oe && state == SB_IDLE) else $error("no reset on timeout");
endmodule : mtc_smb
`default_nettype wire

// ### hw/mtc_ctrl.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mtc_ctrl #(
	parameter int TIMEOUT_CYC = mtc_pkg::TIMEOUT_CYC
) (
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	input  wire logic [7:0]        i_reg_addr,
	input  wire logic [7:0]        i_reg_wdata,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	output logic [7:0]             o_reg_rdata,
	input  wire logic              i_standby_n_input,
	input  wire logic              i_smb_clk,
	input  wire logic              i_smb_data,
	output logic                   o_smb_data,
	output logic                   o_smb_data_oe,
	input  wire logic              i_overtemp_n_input,
	output logic                   o_overtemp_n_output,
	output logic                   o_overtemp_n_output_oe,
	input  wire logic              i_alert_n_input,
	output logic                   o_alert_n_output,
	output logic                   o_alert_n_output_oe,
	output logic                   o_adc_clk_en,
	output logic                   o_adc_enable,
	output mtc_pkg::mtc_conv_t     o_conv,
	input  wire mtc_pkg::mtc_res_t i_res,
	output logic                   o_irq
);
	import mtc_pkg::*;
	typedef enum {SQ_IDLE, SQ_START, SQ_WAIT} mtc_sq_t;

	// ====================================================
	// Helpers
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
		in_bank = (a >= base) && (a < base + 8'(NUM_CH));
	endfunction : in_bank

	function automatic logic [2:0] chan_of(input logic [2:0] s, input logic ilv);
		logic [2:0] i;
		i = ilv ? 3'({1'b0, s[2:1]} + 3'h1) : s;
		case (i)
			3'h0: chan_of = CH_R1;
			3'h1: chan_of = CH_R2;
			3'h2: chan_of = CH_R3;
			3'h3: chan_of = CH_LOCAL;
			default: chan_of = CH_R4;
		endcase
		if (ilv && !s[0]) begin
			chan_of = CH_R1;
		end
	endfunction : chan_of

	// ====================================================
	// State
	logic [2:0]                p1, p2, p3, pins, next_pins;
	logic                      hw_standby_n_input, standby;
	logic [NUM_CH-1:0][7:0]    temp, next_temp, thr, next_thr;
	logic [1:0][7:0]           ovt, next_ovt;
	logic [7:0]                cfg, next_cfg, irq_en, next_en, irq_stat, next_stat;
	logic [7:0]                clr, ev, next_rdata, smb_rdata, smb_cmd;
	logic [NUM_CH-1:0]         alerts, next_alerts;
	logic                      over, next_over, next_irq;
	mtc_wr_t                   smb_wr;
	mtc_wr_t                   wsrc [0:1];
	logic                      smb_tmo, smb_oe;
	mtc_sq_t                   sq, next_sq;
	logic [2:0]                step, next_step, last;
	mtc_conv_t                 next_conv;
	logic                      wr_result, seq_done;

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (in_bank(a, A_TEMP)) begin
			d = temp[3'(a - A_TEMP)];
		end else if (in_bank(a, A_ALERT)) begin
			d = thr[3'(a - A_ALERT)];
		end else begin
			case (a)
				A_OVT1: d = ovt[0];
				A_OVT4: d = ovt[1];
				A_CFG1: d = cfg;
				A_ALARM: d = {2'h0, over, alerts};
				A_IRQ_STAT: d = irq_stat;
				A_IRQ_EN: d = irq_en;
				A_PINS: d = {5'h00, pins};
				default: d = 8'h00;
			endcase
		end
		reg_read = d;
	endfunction : reg_read

	// ====================================================
	// Pin synchronisers: standby, alert, overtemp
	// A level counts only once the second and third stage agree
	always_comb begin
		next_pins = (p2 & ~(p2 ^ p3)) | (pins & (p2 ^ p3));
		hw_standby_n_input = ~pins[0];
		standby = hw_standby_n_input | cfg[CFG_HALT_BIT];
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			p1 <= 3'h7;
			p2 <= 3'h7;
			p3 <= 3'h7;
			pins <= 3'h7;
		end else begin
			p1 <= {i_overtemp_n_input, i_alert_n_input, i_standby_n_input};
			p2 <= p1;
			p3 <= p2;
			pins <= next_pins;
		end
	end

	// ====================================================
	// Serial interface
	// Keeps running in both standby modes
	mtc_smb #(
		.TIMEOUT_CYC (TIMEOUT_CYC)
	) u_smb (
		.i_clock   (i_clock),
		.i_rst     (i_rst),
		.i_scl     (i_smb_clk),
		.i_sda     (i_smb_data),
		.i_rdata   (smb_rdata),
		.o_sda_oe  (smb_oe),
		.o_cmd     (smb_cmd),
		.o_wr      (smb_wr),
		.o_timeout (smb_tmo)
	);

	assign smb_rdata = reg_read(smb_cmd);
	assign o_smb_data = 1'b0;
	assign o_smb_data_oe = smb_oe;

	// ====================================================
	// Conversion sequencer
	always_comb begin
		next_sq = sq;
		next_step = step;
		next_conv = '{start: 1'b0, abort: 1'b0, channel: o_conv.channel};
		wr_result = 1'b0;
		seq_done = 1'b0;
		last = cfg[CFG_ILV_BIT] ? SEQ_LAST_ILV : SEQ_LAST_DEF;
		case (sq)
			SQ_IDLE: begin
				if (!standby) begin
					next_sq = SQ_START;
					next_step = 3'h0;
				end
			end
			SQ_START: begin
				if (standby) begin
					next_sq = SQ_IDLE;
				end else begin
					next_conv.start = 1'b1;
					next_conv.channel = chan_of(step, cfg[CFG_ILV_BIT]);
					next_sq = SQ_WAIT;
				end
			end
			SQ_WAIT: begin
				if (standby) begin
					next_sq = SQ_IDLE;
					next_conv.abort = 1'b1;
				end else if (i_res.done) begin
					wr_result = 1'b1;
					seq_done = step >= last;
					next_step = (step >= last) ? 3'h0 : step + 3'h1;
					next_sq = SQ_START;
				end
			end
			default: next_sq = SQ_IDLE;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sq <= SQ_IDLE;
			step <= 3'h0;
			o_conv <= '0;
			o_adc_clk_en <= 1'b0;
			o_adc_enable <= 1'b0;
		end else begin
			sq <= next_sq;
			step <= next_step;
			o_conv <= next_conv;
			o_adc_clk_en <= ~hw_standby_n_input;
			o_adc_enable <= ~standby;
		end
	end

	// ====================================================
	// Register file
	// Port write lands after a bus write to the same register
	always_comb begin
		next_temp = temp;
		next_thr = thr;
		next_ovt = ovt;
		next_cfg = cfg;
		next_en = irq_en;
		clr = 8'h00;
		wsrc[0] = smb_wr;
		wsrc[1] = '{wr: i_reg_wr, addr: i_reg_addr, data: i_reg_wdata};
		for (int k = 0; k < 2; k++) begin
			if (wsrc[k].wr) begin
				if (in_bank(wsrc[k].addr, A_ALERT)) begin
					next_thr[3'(wsrc[k].addr - A_ALERT)] = wsrc[k].data;
				end
				case (wsrc[k].addr)
					A_OVT1: next_ovt[0] = wsrc[k].data;
					A_OVT4: next_ovt[1] = wsrc[k].data;
					A_CFG1: next_cfg = wsrc[k].data;
					A_IRQ_EN: next_en = wsrc[k].data;
					A_IRQ_CLR: clr = wsrc[k].data;
					default: ;
				endcase
			end
		end
		if (wr_result) begin
			next_temp[o_conv.channel] = i_res.result;
		end
		next_rdata = i_reg_rd ? reg_read(i_reg_addr) : 8'h00;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			temp <= {NUM_CH{RST_TEMP}};
			thr <= {NUM_CH{RST_ALERT}};
			ovt <= {2{RST_OVT}};
			cfg <= RST_CFG;
			irq_en <= RST_IRQ_EN;
			o_reg_rdata <= 8'h00;
		end else begin
			temp <= next_temp;
			thr <= next_thr;
			ovt <= next_ovt;
			cfg <= next_cfg;
			irq_en <= next_en;
			o_reg_rdata <= next_rdata;
		end
	end

	// ====================================================
	// Alarms and interrupt
	// Set wins over a clear in the same cycle so no event is lost
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			next_alerts[i] = temp[i] > thr[i];
		end
		next_over = (temp[CH_R1] > ovt[0]) || (temp[CH_R4] > ovt[1]);
		ev = 8'h00;
		ev[IRQ_SEQ] = seq_done;
		ev[IRQ_ALERT] = (|next_alerts) & ~(|alerts);
		ev[IRQ_OVT] = next_over & ~over;
		ev[IRQ_TMO] = smb_tmo;
		ev[IRQ_ABORT] = next_conv.abort;
		next_stat = (irq_stat & ~clr) | ev;
		next_irq = |(next_stat & next_en);
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			alerts <= '0;
			over <= 1'b0;
			irq_stat <= 8'h00;
			o_irq <= 1'b0;
		end else begin
			alerts <= next_alerts;
			over <= next_over;
			irq_stat <= next_stat;
			o_irq <= next_irq;
		end
	end

	assign o_alert_n_output = 1'b0;
	assign o_alert_n_output_oe = |alerts;
	assign o_overtemp_n_output = 1'b0;
	assign o_overtemp_n_output_oe = over;

	// ====================================================
	// Checks
	a_standby_n_input_pin_halt: assert property (@(posedge i_clock) disable iff (i_rst)
		!pins[0] |=> !o_conv.start && !o_adc_clk_en) else $error("converting in hw standby");
	a_halt_bit_stop: assert property (@(posedge i_clock) disable iff (i_rst)
		cfg[CFG_HALT_BIT] |=> !o_adc_enable && !o_conv.start) else $error("halt ignored");
	a_abort_keeps: assert property (@(posedge i_clock) disable iff (i_rst)
		(sq == SQ_WAIT && standby) |=> o_conv.abort && sq == SQ_IDLE && $stable(temp))
		else $error("abort changed data");
	a_result_stored: assert property (@(posedge i_clock) disable iff (i_rst)
		(sq == SQ_WAIT && !standby && i_res.done)
		|=> temp[$past(o_conv.channel)] == $past(i_res.result)) else $error("result lost");
	a_order_default: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_conv.start && !$past(cfg[CFG_ILV_BIT])) |-> o_conv.channel ==
		((step == 3'h0) ? 3'h1 : (step == 3'h1) ? 3'h2 : (step == 3'h2) ? 3'h3 :
		(step == 3'h3) ? 3'h0 : 3'h4)) else $error("default order wrong");
	a_order_ilv: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_conv.start && $past(cfg[CFG_ILV_BIT]))
		|-> (step[0] ? o_conv.channel != 3'h1 : o_conv.channel == 3'h1))
		else $error("interleave order wrong");
	a_over_drive: assert property (@(posedge i_clock) disable iff (i_rst)
		(temp[CH_R4] > ovt[1]) |=> o_overtemp_n_output_oe) else $error("overtemp not driven");
	a_alert_drive: assert property (@(posedge i_clock) disable iff (i_rst)
		((|alerts) == o_alert_n_output_oe) and ((temp[CH_LOCAL] > thr[CH_LOCAL]) |=> |alerts))
		else $error("alert not driven");
	a_restart_seq: assert property (@(posedge i_clock) disable iff (i_rst)
		(sq == SQ_IDLE && !standby) ##1 !standby |=> o_conv.start && step == 3'h0)
		else $error("no restart at step 0");
endmodule : mtc_ctrl
`default_nettype wire

// ### tb/mtc_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Converter stand-in: answers each start after a set delay
module mtc_adc_model (
	input  wire logic               i_clock,
	input  wire logic               i_rst,
	input  wire mtc_pkg::mtc_conv_t i_conv,
	input  wire logic [4:0][7:0]    i_temps,
	input  wire logic [7:0]         i_delay,
	output mtc_pkg::mtc_res_t       o_res
);
	import mtc_pkg::*;
	logic [7:0] cnt;
	logic       busy;
	logic [2:0] ch;
	always_ff @(posedge i_clock) begin
		o_res.done <= 1'b0;
		// Result toggles between answers so stale data never looks valid
		o_res.result <= ~o_res.result;
		if (i_rst || i_conv.abort) begin
			busy <= 1'b0;
			o_res.result <= 8'h00;
		end else if (i_conv.start) begin
			busy <= 1'b1;
			cnt  <= i_delay;
			ch   <= i_conv.channel;
		end else if (busy && cnt == 8'h00) begin
			busy         <= 1'b0;
			o_res.done   <= 1'b1;
			o_res.result <= i_temps[ch];
		end else begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule : mtc_adc_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mtc_pkg::*;
	localparam int         TMO     = 200;
	localparam int         LIMIT   = 20000;
	localparam logic [6:0] DEV_ADR = 7'h2a;
	localparam logic [7:0] M_ALERT = 8'h01 << IRQ_ALERT;
	localparam logic [7:0] M_TMO   = 8'h01 << IRQ_TMO;
	logic            i_clock = 1'b0;
	logic            i_rst = 1'b1;
	logic [7:0]      i_reg_addr = 8'h00;
	logic [7:0]      i_reg_wdata = 8'h00;
	logic            i_reg_wr = 1'b0;
	logic            i_reg_rd = 1'b0;
	logic            i_standby_n_input = 1'b1;
	logic            h_scl = 1'b1;
	logic            h_sda = 1'b1;
	logic [4:0][7:0] temps = {8'h28, 8'h26, 8'h24, 8'h22, 8'h20};
	logic [7:0]      delay = 8'h28;
	logic [7:0]      o_reg_rdata;
	logic            smb_out, smb_oe, ovt_out, ovt_oe, alt_out, alt_oe;
	logic            o_adc_clk_en, o_adc_enable, o_irq;
	mtc_conv_t       o_conv;
	mtc_res_t        i_res;
	logic            sda_wire, ovt_wire, alt_wire;
	logic [2:0]      seq_q[$];
	logic [7:0]      rx_byte;
	int              n_abort = 0;
	int              mismatches = 0;
	int              n_compared = 0;
	int              cycles = 0;
	// Pull-ups on all open-drain wires
	assign sda_wire = h_sda & (smb_oe ? smb_out : 1'b1);
	assign ovt_wire = ovt_oe ? ovt_out : 1'b1;
	assign alt_wire = alt_oe ? alt_out : 1'b1;
	logic [15:0] rows[15] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h1050,
		16'h1150, 16'h1250, 16'h1350, 16'h1450, 16'h2064, 16'h2164, 16'h3000, 16'h4307, 16'hff00};
	// Alarm rows: address, threshold, overtemp level, alert level
	logic [17:0] arows[16] = '{{8'h20, 8'h22, 2'b11}, {8'h20, 8'h21, 2'b01},
		{8'h20, 8'h64, 2'b11}, {8'h21, 8'h28, 2'b11}, {8'h21, 8'h27, 2'b01},
		{8'h21, 8'h64, 2'b11}, {8'h10, 8'h20, 2'b11}, {8'h10, 8'h1f, 2'b10},
		{8'h10, 8'h50, 2'b11}, {8'h11, 8'h21, 2'b10}, {8'h11, 8'h50, 2'b11},
		{8'h12, 8'h23, 2'b10}, {8'h12, 8'h50, 2'b11}, {8'h13, 8'h25, 2'b10},
		{8'h13, 8'h50, 2'b11}, {8'h14, 8'h27, 2'b10}};
	logic [2:0]  def_seq[10] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h1, 3'h2, 3'h3, 3'h0, 3'h4};
	logic [2:0]  ilv_seq[8] = '{3'h1, 3'h2, 3'h1, 3'h3, 3'h1, 3'h0, 3'h1, 3'h4};

	always #5 i_clock = ~i_clock;

	mtc_ctrl #(.TIMEOUT_CYC(TMO)) u_dut (
		.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .i_standby_n_input(i_standby_n_input),
		.i_smb_clk(h_scl), .i_smb_data(sda_wire), .o_smb_data(smb_out),
		.o_smb_data_oe(smb_oe), .i_overtemp_n_input(ovt_wire),
		.o_overtemp_n_output(ovt_out), .o_overtemp_n_output_oe(ovt_oe),
		.i_alert_n_input(alt_wire), .o_alert_n_output(alt_out),
		.o_alert_n_output_oe(alt_oe), .o_adc_clk_en(o_adc_clk_en),
		.o_adc_enable(o_adc_enable), .o_conv(o_conv), .i_res(i_res), .o_irq(o_irq));

	mtc_adc_model u_adc (.i_clock(i_clock), .i_rst(i_rst), .i_conv(o_conv),
		.i_temps(temps), .i_delay(delay), .o_res(i_res));

	always @(posedge i_clock) begin
		if (!i_rst && o_conv.start) seq_q.push_back(o_conv.channel);
		if (!i_rst && o_conv.abort) n_abort++;
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			test_done();
		end
	end

	// ====================================================
	// Shared tasks
	task automatic test_done;
		if (mismatches == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask : tick
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		i_reg_wr    <= 1'b1;
		i_reg_addr  <= a;
		i_reg_wdata <= v;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
		@(posedge i_clock);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		i_reg_rd   <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clock);
		i_reg_rd <= 1'b0;
		@(posedge i_clock);
		v = o_reg_rdata;
	endtask : reg_rd
	task automatic wait_starts(input int n);
		int k;
		k = 0;
		while (seq_q.size() < n && k < 3000) begin
			@(posedge i_clock);
			k++;
		end
		chk(8'(seq_q.size() >= n), 8'h01);
	endtask : wait_starts
	task automatic smb_start;
		h_sda <= 1'b1;
		h_scl <= 1'b1;
		tick(8);
		h_sda <= 1'b0;
		tick(8);
		h_scl <= 1'b0;
		tick(2);
	endtask : smb_start
	task automatic smb_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			h_sda <= b[i];
			tick(6);
			h_scl <= 1'b1;
			tick(6);
			rx_byte[i] = sda_wire;
			tick(2);
			h_scl <= 1'b0;
			tick(2);
		end
		// Host lets go of data so the device can acknowledge
		h_sda <= 1'b1;
		tick(6);
		h_scl <= 1'b1;
		tick(6);
		ack = ~sda_wire;
		tick(2);
		h_scl <= 1'b0;
		tick(2);
	endtask : smb_byte
	task automatic smb_write(input logic [7:0] cmd, input logic [7:0] v);
		logic ack;
		smb_start();
		smb_byte({DEV_ADR, 1'b0}, ack);
		chk({7'h00, ack}, 8'h01);
		smb_byte(cmd, ack);
		chk({7'h00, ack}, 8'h01);
		smb_byte(v, ack);
		chk({7'h00, ack}, 8'h01);
		smb_stop();
	endtask : smb_write
	task automatic smb_stop;
		h_sda <= 1'b0;
		tick(8);
		h_scl <= 1'b1;
		tick(8);
		h_sda <= 1'b1;
		tick(8);
	endtask : smb_stop

	// ====================================================
	// Main sequence
	initial begin
		logic [7:0] d;
		logic       ack;
		logic [2:0] ab_ch;
		int         k;
		tick(6);
		i_rst <= 1'b0;
		@(posedge i_clock);
		foreach (rows[i]) begin
			reg_rd(rows[i][15:8], d);
			chk(d, rows[i][7:0]);
		end
		wait_starts(10);
		foreach (def_seq[i]) chk({5'h00, seq_q[i]}, {5'h00, def_seq[i]});
		for (int c = 0; c < 5; c++) begin
			reg_rd(A_TEMP + 8'(c), d);
			chk(d, temps[c]);
		end
		reg_wr(A_TEMP + 8'h01, 8'hff);
		reg_rd(A_TEMP + 8'h01, d);
		chk(d, temps[1]);
		foreach (arows[i]) begin
			reg_wr(arows[i][17:10], arows[i][9:2]);
			tick(4);
			chk({6'h00, ovt_wire, alt_wire}, {6'h00, arows[i][1:0]});
		end
		reg_wr(A_ALERT + 8'h04, 8'h50);
		// ====================================================
		// Interrupt raise, clear and mask
		reg_wr(A_IRQ_EN, M_ALERT);
		tick(3);
		chk({7'h00, o_irq}, 8'h01);
		reg_wr(A_IRQ_CLR, M_ALERT);
		tick(3);
		chk({7'h00, o_irq}, 8'h00);
		reg_wr(A_IRQ_EN, 8'h00);
		reg_wr(A_ALERT, 8'h1f);
		tick(3);
		chk({7'h00, o_irq}, 8'h00);
		reg_rd(A_IRQ_STAT, d);
		chk(d & M_ALERT, M_ALERT);
		reg_wr(A_ALERT, 8'h50);
		// ====================================================
		// Software standby in mid conversion
		wait_starts(seq_q.size() + 1);
		ab_ch = seq_q[$];
		d = temps[ab_ch];
		temps[ab_ch] <= d + 8'h01;
		tick(5);
		k = n_abort;
		reg_wr(A_CFG1, 8'h40);
		tick(6);
		chk({7'h00, o_adc_enable}, 8'h00);
		chk(8'(n_abort > k), 8'h01);
		seq_q.delete();
		tick(200);
		chk(8'(seq_q.size()), 8'h00);
		reg_rd(A_TEMP + 8'(ab_ch), d);
		chk(d, temps[ab_ch] - 8'h01);
		reg_wr(A_CFG1, 8'h10);
		wait_starts(8);
		foreach (ilv_seq[i]) chk({5'h00, seq_q[i]}, {5'h00, ilv_seq[i]});
		// ====================================================
		// Hardware standby with bus traffic meanwhile
		reg_wr(A_CFG1, 8'h00);
		wait_starts(seq_q.size() + 1);
		tick(5);
		k = n_abort;
		i_standby_n_input <= 1'b0;
		tick(8);
		chk({7'h00, o_adc_clk_en}, 8'h00);
		chk(8'(n_abort > k), 8'h01);
		seq_q.delete();
		smb_write(A_ALERT + 8'h03, 8'h77);
		reg_rd(A_ALERT + 8'h03, d);
		chk(d, 8'h77);
		chk(8'(seq_q.size()), 8'h00);
		i_standby_n_input <= 1'b1;
		wait_starts(1);
		chk({5'h00, seq_q[0]}, 8'h01);
		chk({7'h00, o_adc_clk_en}, 8'h01);
		// ====================================================
		// Bus timeout armed only after a start
		reg_wr(A_IRQ_CLR, 8'hff);
		h_scl <= 1'b0;
		tick(2 * TMO);
		h_scl <= 1'b1;
		tick(8);
		reg_rd(A_IRQ_STAT, d);
		chk(d & M_TMO, 8'h00);
		smb_start();
		smb_byte({DEV_ADR, 1'b0}, ack);
		tick(2 * TMO);
		reg_rd(A_IRQ_STAT, d);
		chk(d & M_TMO, M_TMO);
		chk({7'h00, smb_oe}, 8'h00);
		h_scl <= 1'b1;
		tick(8);
		h_sda <= 1'b1;
		tick(8);
		smb_write(A_ALERT + 8'h04, 8'h66);
		reg_rd(A_ALERT + 8'h04, d);
		chk(d, 8'h66);
		// Receive byte reuses the last command: remote 4 threshold
		smb_start();
		smb_byte({DEV_ADR, 1'b1}, ack);
		chk({7'h00, ack}, 8'h01);
		smb_byte(8'hff, ack);
		chk(rx_byte, 8'h66);
		smb_stop();
		test_done();
	end
endmodule : testbench
`default_nettype wire
